// file: hdl/signal_measure_timer.sv
// Signal measure counter: counter, gated counter and windowed counter modes.
// Assumes an APB master on CLOCK and asynchronous signal and window source pins.
`timescale 1ns/1ps
module signal_measure_timer (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic ARST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Selectable sources
  input wire logic [measure_pkg::SRC_COUNT-1:0] SIGNAL_SRC,
  input wire logic [measure_pkg::SRC_COUNT-1:0] WINDOW_SRC,
  // Interrupt
  output logic IRQ
);
  import measure_pkg::*;

  apb_req_t req;
  logic [11:0] idx;
  logic addr_ok;
  logic hit;
  logic setup;
  logic wr;
  logic [7:0] wbyte;

  // Software-visible state and the internal window arming flag
  logic [23:0] count;
  logic [23:0] captured_period;
  logic [23:0] captured_width;
  logic [23:0] period_limit;
  control_primary_t control_primary;
  control_mode_t control_mode;
  logic [7:0] clock_select;
  logic [7:0] signal_select;
  logic [7:0] window_select;
  logic armed;

  // Bus request carried as one struct
  assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};
  assign idx = req.addr[13:2];
  assign wbyte = req.wdata[7:0];
  assign setup = req.sel & ~req.enable;
  assign wr = req.sel & req.enable & PREADY & req.write;

  // Address decode
  assign hit = ((idx >= IDX_COUNT_LOW) && (idx <= IDX_WINDOW_SELECT))
             || (idx == IDX_IRQ_STATUS) || (idx == IDX_IRQ_CLEAR) || (idx == IDX_IRQ_ENABLE);
  assign addr_ok = hit && (req.addr[1:0] == 2'b00) && (req.addr[15:14] == 2'b00);

  // Per-register write strobes
  logic wr_cl;
  logic wr_ch;
  logic wr_cu;
  logic wr_pl;
  logic wr_ph;
  logic wr_pu;
  logic wr_ctl;
  logic wr_mode;
  logic wr_stat;
  logic wr_clk;
  logic wr_sig;
  logic wr_win;
  logic wr_iclr;
  logic wr_ien;
  assign wr_cl = wr & (idx == IDX_COUNT_LOW);
  assign wr_ch = wr & (idx == IDX_COUNT_HIGH);
  assign wr_cu = wr & (idx == IDX_COUNT_UPPER);
  assign wr_pl = wr & (idx == IDX_PR_LOW);
  assign wr_ph = wr & (idx == IDX_PR_HIGH);
  assign wr_pu = wr & (idx == IDX_PR_UPPER);
  assign wr_ctl = wr & (idx == IDX_CONTROL_PRIMARY);
  assign wr_mode = wr & (idx == IDX_CONTROL_MODE);
  assign wr_stat = wr & (idx == IDX_STATUS_FLAGS);
  assign wr_clk = wr & (idx == IDX_CLOCK_SELECT);
  assign wr_sig = wr & (idx == IDX_SIGNAL_SELECT);
  assign wr_win = wr & (idx == IDX_WINDOW_SELECT);
  assign wr_iclr = wr & (idx == IDX_IRQ_CLEAR);
  assign wr_ien = wr & (idx == IDX_IRQ_ENABLE);

  // Status-register command bits
  logic cmd_clear;
  logic cmd_cprup;
  logic cmd_cpwup;
  assign cmd_clear = wr_stat & wbyte[STAT_RST];
  assign cmd_cprup = wr_stat & wbyte[STAT_CPRUP];
  assign cmd_cpwup = wr_stat & wbyte[STAT_CPWUP];

  // Every source pin is synchronised before selection; only CLOCK is needed, no gating
  logic [SRC_COUNT-1:0] s_lvl;
  logic [SRC_COUNT-1:0] s_up;
  logic [SRC_COUNT-1:0] s_dn;
  logic [SRC_COUNT-1:0] w_lvl;
  logic [SRC_COUNT-1:0] w_up;
  logic [SRC_COUNT-1:0] w_dn;
  for (genvar g = 0; g < SRC_COUNT; g++) begin : g_src
    sync_edge u_sig_sync (
      .clock(CLOCK),
      .arst_n(ARST_N),
      .din(SIGNAL_SRC[g]),
      .level(s_lvl[g]),
      .rise(s_up[g]),
      .fall(s_dn[g])
    );
    sync_edge u_win_sync (
      .clock(CLOCK),
      .arst_n(ARST_N),
      .din(WINDOW_SRC[g]),
      .level(w_lvl[g]),
      .rise(w_up[g]),
      .fall(w_dn[g])
    );
  end

  // Selected synchronised source and its edge pulses
  wire logic s_level = s_lvl[signal_select[2:0]];
  wire logic s_rise = s_up[signal_select[2:0]];
  wire logic s_fall = s_dn[signal_select[2:0]];
  wire logic w_level = w_lvl[window_select[2:0]];
  wire logic w_rise = w_up[window_select[2:0]];
  wire logic w_fall = w_dn[window_select[2:0]];

  // Polarity applied after synchronisation
  logic sig_level;
  logic sig_pulse;
  logic win_level;
  logic win_rise;
  logic win_fall;
  assign sig_level = s_level ^ control_primary.signal_pol;
  assign sig_pulse = control_primary.signal_pol ? s_fall : s_rise;
  assign win_level = w_level ^ control_primary.window_pol;
  assign win_rise = control_primary.window_pol ? w_fall : w_rise;
  assign win_fall = control_primary.window_pol ? w_rise : w_fall;

  // Mode decode
  logic running;
  logic m_counter;
  logic m_gated;
  logic m_windowed;
  assign running = control_primary.enable & control_mode.run_request;
  assign m_counter = control_mode.mode == MODE_COUNTER;
  assign m_gated = control_mode.mode == MODE_GATED_COUNTER;
  assign m_windowed = control_mode.mode == MODE_WINDOWED_COUNTER;

  // Count qualification; each signal pulse is one tick of the time base
  logic gate_open;
  logic tick;
  assign gate_open = m_counter
                   | (m_gated & armed & win_level)
                   | (m_windowed & armed);
  assign tick = running & sig_pulse & gate_open;

  // Hardware capture events
  logic hw_cap_w;
  logic hw_cap_p;
  logic cap_w;
  logic cap_p;
  assign hw_cap_w = running & win_fall & (m_counter | ((m_gated | m_windowed) & armed));
  assign hw_cap_p = running & win_rise & m_windowed & armed;
  assign cap_w = hw_cap_w | cmd_cpwup;
  assign cap_p = hw_cap_p | cmd_cprup;

  // End of one acquisition in single mode
  logic acq_done;
  assign acq_done = ~control_mode.repeat_acq
                  & (m_windowed ? hw_cap_p : hw_cap_w);

  // Increment with period match handling
  logic [23:0] count_inc;
  logic at_limit;
  logic reach_limit;
  logic match;
  assign count_inc = count + 24'h000001;
  assign at_limit = count == period_limit;
  assign reach_limit = count_inc == period_limit;
  assign match = tick & ~at_limit & reach_limit;

  // Next count, software first, then hardware
  logic [23:0] next_count;
  always_comb begin
    next_count = count;
    if (cmd_clear) begin
      next_count = COUNT_RESET;
    end else if (wr_cl | wr_ch | wr_cu) begin
      if (wr_cl) next_count[7:0] = wbyte;
      if (wr_ch) next_count[15:8] = wbyte;
      if (wr_cu) next_count[23:16] = wbyte;
    end else if (hw_cap_p) begin
      next_count = COUNT_RESET;
    end else if (tick) begin
      if (at_limit) begin
        next_count = control_primary.halt_at_match ? count : COUNT_RESET;
      end else if (reach_limit && !control_primary.halt_at_match) begin
        next_count = COUNT_RESET;
      end else begin
        next_count = count_inc;
      end
    end
  end

  // Measure count register
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      count <= COUNT_RESET;
    end else begin
      count <= next_count;
    end
  end

  // Capture registers
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      captured_width <= CAPTURE_RESET;
      captured_period <= CAPTURE_RESET;
    end else begin
      if (cap_w) captured_width <= count;
      if (cap_p) captured_period <= count;
    end
  end

  // Window arming: first rise opens counting, cleared while stopped
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      armed <= 1'b0;
    end else if (!running || m_counter) begin
      armed <= 1'b0;
    end else if (win_rise) begin
      armed <= 1'b1;
    end
  end

  // Next mode control, go cleared by a finished single acquisition
  control_mode_t next_mode;
  always_comb begin
    next_mode = control_mode;
    if (wr_mode) begin
      next_mode = control_mode_t'(wbyte);
    end else if (acq_done) begin
      next_mode.run_request = 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      control_primary <= control_primary_t'(BYTE_RESET);
      control_mode <= control_mode_t'(BYTE_RESET);
      clock_select <= BYTE_RESET;
      signal_select <= BYTE_RESET;
      window_select <= BYTE_RESET;
    end else begin
      control_mode <= next_mode;
      if (wr_ctl) control_primary <= control_primary_t'(wbyte);
      if (wr_clk) clock_select <= wbyte;
      if (wr_sig) signal_select <= wbyte;
      if (wr_win) window_select <= wbyte;
    end
  end

  // Period limit, byte writable
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      period_limit <= LIMIT_RESET;
    end else begin
      if (wr_pl) period_limit[7:0] <= wbyte;
      if (wr_ph) period_limit[15:8] <= wbyte;
      if (wr_pu) period_limit[23:16] <= wbyte;
    end
  end

  // Interrupt events
  logic [IRQ_COUNT-1:0] irq_set;
  logic [IRQ_COUNT-1:0] irq_status;
  logic [IRQ_COUNT-1:0] irq_enable;
  logic irq_level;
  assign irq_set[IRQ_WIDTH_CAPTURE] = cap_w;
  assign irq_set[IRQ_PERIOD_CAPTURE] = cap_p;
  assign irq_set[IRQ_PERIOD_MATCH] = match;

  // Sticky flags with per-source enables
  irq_flags #(
    .N(IRQ_COUNT)
  ) u_irq (
    .clock(CLOCK),
    .arst_n(ARST_N),
    .set(irq_set),
    .clear_wr(wr_iclr),
    .enable_wr(wr_ien),
    .wdata(wbyte[IRQ_COUNT-1:0]),
    .status(irq_status),
    .enable(irq_enable),
    .irq(irq_level)
  );

  // Live status byte; command bits read as zero
  logic [7:0] status_byte;
  assign status_byte = {5'b00000, running, win_level, sig_level};

  // Read multiplexer
  logic [7:0] rbyte;
  always_comb begin
    case (idx)
      IDX_COUNT_LOW: rbyte = count[7:0];
      IDX_COUNT_HIGH: rbyte = count[15:8];
      IDX_COUNT_UPPER: rbyte = count[23:16];
      IDX_CPR_LOW: rbyte = captured_period[7:0];
      IDX_CPR_HIGH: rbyte = captured_period[15:8];
      IDX_CPR_UPPER: rbyte = captured_period[23:16];
      IDX_CPW_LOW: rbyte = captured_width[7:0];
      IDX_CPW_HIGH: rbyte = captured_width[15:8];
      IDX_CPW_UPPER: rbyte = captured_width[23:16];
      IDX_PR_LOW: rbyte = period_limit[7:0];
      IDX_PR_HIGH: rbyte = period_limit[15:8];
      IDX_PR_UPPER: rbyte = period_limit[23:16];
      IDX_CONTROL_PRIMARY: rbyte = control_primary;
      IDX_CONTROL_MODE: rbyte = control_mode;
      IDX_STATUS_FLAGS: rbyte = status_byte;
      IDX_CLOCK_SELECT: rbyte = clock_select;
      IDX_SIGNAL_SELECT: rbyte = signal_select;
      IDX_WINDOW_SELECT: rbyte = window_select;
      IDX_IRQ_STATUS: rbyte = {5'b00000, irq_status};
      IDX_IRQ_ENABLE: rbyte = {5'b00000, irq_enable};
      default: rbyte = BYTE_RESET;
    endcase
  end

  // APB answer registered in the setup cycle, ready for one access cycle
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup & ~addr_ok;
      if (setup) begin
        PRDATA <= (addr_ok && !req.write) ? {24'h000000, rbyte} : 32'h00000000;
      end
    end
  end

  // Interrupt output register
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= irq_level;
    end
  end

endmodule : signal_measure_timer

// file: inc/measure_pkg.sv
// Constants, field layouts and carrier types of the signal measure counter.
// Assumes an APB master on the register side and asynchronous source pins.
// Operation
// - In counter mode the count rises by one for every pulse on the chosen signal input.
// - In counter mode the signal input, not the measurement clock, is the time source.
// - In counter mode each falling window edge copies the count into captured width.
// - In gated counter mode pulses are counted only while the window allows it.
// - In gated counter mode counting starts at a rising window edge; every fall after it captures width.
// - In windowed counter mode counting starts at a rising edge; each fall captures width.
// - In windowed counter mode every rising window edge after the first captures period.
// - The width capture flag is set whenever captured width receives a new value.
// - The period capture flag is set whenever captured period receives a new value.
// - The period match flag is set when a counted pulse would bring the count to the period limit.
// - Each of the three interrupt sources has its own enable bit.
// - The block keeps working in low-power states while its clock and sources run.
// - The count is a 24-bit read/write register at 0x048C that resets to zero.
// - The count is reached byte by byte through upper, high and low byte registers.
// - A repeat bit picks single acquisition, which halts and clears go, or continuous.
// - Writing one to the counter clear bit of the status register zeroes the count.
// - At a period match the count holds at the limit if halt is set, else returns to zero.
package measure_pkg;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_COUNT_LOW = 12'h48C;
  localparam logic [11:0] IDX_COUNT_HIGH = 12'h48D;
  localparam logic [11:0] IDX_COUNT_UPPER = 12'h48E;
  localparam logic [11:0] IDX_CPR_LOW = 12'h48F;
  localparam logic [11:0] IDX_CPR_HIGH = 12'h490;
  localparam logic [11:0] IDX_CPR_UPPER = 12'h491;
  localparam logic [11:0] IDX_CPW_LOW = 12'h492;
  localparam logic [11:0] IDX_CPW_HIGH = 12'h493;
  localparam logic [11:0] IDX_CPW_UPPER = 12'h494;
  localparam logic [11:0] IDX_PR_LOW = 12'h495;
  localparam logic [11:0] IDX_PR_HIGH = 12'h496;
  localparam logic [11:0] IDX_PR_UPPER = 12'h497;
  localparam logic [11:0] IDX_CONTROL_PRIMARY = 12'h498;
  localparam logic [11:0] IDX_CONTROL_MODE = 12'h499;
  localparam logic [11:0] IDX_STATUS_FLAGS = 12'h49A;
  localparam logic [11:0] IDX_CLOCK_SELECT = 12'h49B;
  localparam logic [11:0] IDX_SIGNAL_SELECT = 12'h49C;
  localparam logic [11:0] IDX_WINDOW_SELECT = 12'h49D;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h4A0;
  localparam logic [11:0] IDX_IRQ_CLEAR = 12'h4A1;
  localparam logic [11:0] IDX_IRQ_ENABLE = 12'h4A2;

  // Reset values
  localparam logic [23:0] COUNT_RESET = 24'h000000;
  localparam logic [23:0] CAPTURE_RESET = 24'h000000;
  localparam logic [23:0] LIMIT_RESET = 24'hFFFFFF;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Status register bit positions
  localparam int STAT_CPRUP = 7;
  localparam int STAT_CPWUP = 6;
  localparam int STAT_RST = 4;
  localparam int STAT_TS = 2;
  localparam int STAT_WS = 1;
  localparam int STAT_AS = 0;

  // Interrupt bit positions
  localparam int IRQ_WIDTH_CAPTURE = 0;
  localparam int IRQ_PERIOD_CAPTURE = 1;
  localparam int IRQ_PERIOD_MATCH = 2;
  localparam int IRQ_COUNT = 3;

  // Width of the selectable source buses
  localparam int SRC_COUNT = 8;

  // Counter-style operating modes
  typedef enum logic [3:0] {
    MODE_COUNTER = 4'h8,
    MODE_GATED_COUNTER = 4'h9,
    MODE_WINDOWED_COUNTER = 4'hA
  } mode_t;

  // Primary control byte
  typedef struct packed {
    logic enable;
    logic spare;
    logic halt_at_match;
    logic window_pol;
    logic signal_pol;
    logic clock_pol;
    logic [1:0] prescale;
  } control_primary_t;

  // Mode control byte
  typedef struct packed {
    logic run_request;
    logic repeat_acq;
    logic [1:0] spare;
    logic [3:0] mode;
  } control_mode_t;

  // APB request as seen by the slave
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [15:0] addr;
    logic [31:0] wdata;
  } apb_req_t;

endpackage : measure_pkg

// file: hdl/sync_edge.sv
// Two-flop synchroniser with rise and fall detection on the synchronised level.
// Assumes an asynchronous input; the outputs are in the CLOCK domain.
`timescale 1ns/1ps
module sync_edge (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Asynchronous input
  input wire logic din,
  // Synchronised level and one-cycle edge pulses
  output logic level,
  output logic rise,
  output logic fall
);

  logic stage1;
  logic stage2;
  logic stage3;

  // Synchroniser chain; stage1 feeds stage2 only
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Edge detection on settled stages
  assign level = stage2;
  assign rise = stage2 & ~stage3;
  assign fall = ~stage2 & stage3;

endmodule : sync_edge

// file: hdl/irq_flags.sv
// Sticky interrupt status, write-one-to-clear, enable mask and one level output.
// Assumes set pulses and register strobes from the same clock.
`timescale 1ns/1ps
module irq_flags #(
  parameter int N = 3
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Event pulses
  input wire logic [N-1:0] set,
  // Register strobes
  input wire logic clear_wr,
  input wire logic enable_wr,
  input wire logic [N-1:0] wdata,
  // State
  output logic [N-1:0] status,
  output logic [N-1:0] enable,
  output logic irq
);

  logic [N-1:0] next_status;
  logic [N-1:0] next_enable;

  // A set in the clearing cycle survives
  assign next_status = (status & ~(clear_wr ? wdata : '0)) | set;
  assign next_enable = enable_wr ? wdata : enable;

  // Flags, mask and registered interrupt level
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      status <= '0;
      enable <= '0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      enable <= next_enable;
      irq <= |(next_status & next_enable);
    end
  end

endmodule : irq_flags

// file: tb/measure_checker.sv
// Concurrent checks on the ports of the signal measure counter.
// Assumes one clock domain and the registered zero-wait APB slave.
`timescale 1ns/1ps
module measure_checker (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic ARST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Sources and interrupt
  input wire logic [measure_pkg::SRC_COUNT-1:0] SIGNAL_SRC,
  input wire logic [measure_pkg::SRC_COUNT-1:0] WINDOW_SRC,
  input wire logic IRQ
);
  import measure_pkg::*;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);

  // Decoded request phases
  wire logic setup;
  wire logic mapped;
  wire logic wr_done;
  assign setup = PSEL && !PENABLE;
  assign mapped = PADDR[1:0] == 2'b00 && PADDR[15:14] == 2'b00 &&
    PADDR[13:2] >= IDX_COUNT_LOW && PADDR[13:2] <= IDX_WINDOW_SELECT;
  assign wr_done = PREADY && PWRITE;

  a_ready_after_setup: assert property (setup |=> PREADY && PSEL && PENABLE)
    else $error("no ready in the access cycle");
  a_ready_in_access: assert property (PREADY |-> PENABLE && $past(setup))
    else $error("ready outside an access cycle");
  a_ready_one_cycle: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_err_zero_data: assert property (PSLVERR |-> PREADY && PRDATA == 32'h00000000)
    else $error("error without ready or with data");
  a_err_misaligned: assert property (setup && PADDR[1:0] != 2'b00 |=> PSLVERR)
    else $error("misaligned access accepted");
  a_mapped_no_err: assert property (setup && mapped |=> !PSLVERR)
    else $error("mapped register refused");
  a_rdata_holds: assert property (!setup |=> $stable(PRDATA))
    else $error("read data moved without a request");
  a_irq_fall_cause: assert property ($fell(IRQ) |->
    $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3))
    else $error("interrupt dropped without a register write");

  // Main scenarios
  c_write: cover property (setup && PWRITE);
  c_error: cover property (PSLVERR);
  c_irq_rise: cover property ($rose(IRQ));
  c_irq_fall: cover property ($fell(IRQ));
endmodule : measure_checker

// file: tb/tb_top.sv
// Self-checking bench for the signal measure counter in its counter modes.
// Assumes the package constants and source 0 selected on both source buses.
`timescale 1ns/1ps
module tb_top;
  import measure_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [7:0] sig = 8'h00;
  logic [7:0] win = 8'h00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  int num_errors = 0;
  int tests_run = 0;
  int seed = 89695;
  logic [7:0] b;
  logic e;
  logic [23:0] w;
  int n;
  int k;

  signal_measure_timer dut (.CLOCK(clock), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SIGNAL_SRC(sig), .WINDOW_SRC(win), .IRQ(irq));

  // Free-running system clock
  always #50 clock = ~clock;

  // Verdict and end of run
  task automatic end_sim();
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  // Compare one value against its expectation
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      num_errors++;
    end
  endtask : chk

  // One APB transfer, waiting a bounded time for ready
  task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd, output logic err);
    int i;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      num_errors++;
      end_sim();
    end
  endtask : bus

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic x;
    bus(1'b1, idx, d, r, x);
  endtask : wr

  // Read a 24-bit value as low, high and upper bytes
  task automatic rd24(input logic [11:0] idx, output logic [23:0] v);
    logic x;
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, idx + 12'(i), 8'h00, v[8*i +: 8], x);
    end
  endtask : rd24

  // Stop, zero the count, drop the flags, then run in the given mode
  task automatic restart(input logic [7:0] mode);
    wr(IDX_CONTROL_MODE, 8'h00);
    wr(IDX_STATUS_FLAGS, 8'h10);
    wr(IDX_IRQ_CLEAR, 8'h07);
    wr(IDX_CONTROL_MODE, mode);
  endtask : restart

  // Pulses of three clocks high and three low on signal source 0
  task automatic pulses(input int cnt);
    repeat (cnt) begin
      @(posedge clock);
      sig[0] <= 1'b1;
      repeat (3) @(posedge clock);
      sig[0] <= 1'b0;
      repeat (2) @(posedge clock);
    end
    repeat (8) @(posedge clock);
  endtask : pulses

  task automatic window(input logic lvl);
    @(posedge clock);
    win[0] <= lvl;
    repeat (8) @(posedge clock);
  endtask : window

  // Count expected after a number of pulses against a limit
  function automatic logic [23:0] exp_cnt(input int cnt, input logic [23:0] lim,
                                          input logic halt);
    logic [23:0] c;
    c = 24'h000000;
    for (int i = 0; i < cnt; i++) begin
      if (halt && c == lim) c = lim;
      else if (c + 24'h000001 == lim) c = halt ? lim : 24'h000000;
      else c = c + 24'h000001;
    end
    return c;
  endfunction : exp_cnt

  // Hang guard
  initial begin
    #(100 * 60000);
    num_errors++;
    end_sim();
  end

  // Main sequence
  initial begin
    sig[7:1] <= 7'($random(seed));
    win[7:1] <= 7'($random(seed));
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    rd24(IDX_COUNT_LOW, w);
    chk(w, COUNT_RESET);
    rd24(IDX_PR_LOW, w);
    chk(w, LIMIT_RESET);
    // Byte access, read-only, unmapped and clear command
    k = $random(seed);
    for (int i = 0; i < 3; i++) wr(IDX_COUNT_LOW + 12'(i), 8'(k >> (8 * i)));
    rd24(IDX_COUNT_LOW, w);
    chk(w, 24'(k));
    wr(IDX_CPR_LOW, 8'h5A);
    rd24(IDX_CPR_LOW, w);
    chk(w, CAPTURE_RESET);
    wr(IDX_STATUS_FLAGS, 8'hC0);
    rd24(IDX_CPW_LOW, w);
    chk(w, 24'(k));
    rd24(IDX_IRQ_STATUS, w);
    chk({16'h0, w[7:0]}, 24'h000003);
    bus(1'b0, 12'h4A5, 8'h00, b, e);
    chk({23'h0, e}, 24'h000001);
    wr(IDX_STATUS_FLAGS, 8'h10);
    rd24(IDX_COUNT_LOW, w);
    chk(w, COUNT_RESET);
    // Counter mode, width capture and interrupt masking
    wr(IDX_IRQ_ENABLE, 8'h07);
    wr(IDX_CONTROL_PRIMARY, 8'h80);
    window(1'b1);
    restart(8'hC8);
    n = 1 + ($random(seed) & 15);
    pulses(n);
    rd24(IDX_COUNT_LOW, w);
    chk(w, exp_cnt(n, LIMIT_RESET, 1'b0));
    window(1'b0);
    rd24(IDX_CPW_LOW, w);
    chk(w, 24'(n));
    rd24(IDX_IRQ_STATUS, w);
    chk({16'h0, w[7:0]}, 24'h000001);
    chk({23'h0, irq}, 24'h000001);
    wr(IDX_IRQ_ENABLE, 8'h06);
    repeat (3) @(posedge clock);
    chk({23'h0, irq}, 24'h000000);
    wr(IDX_IRQ_ENABLE, 8'h07);
    wr(IDX_IRQ_CLEAR, 8'h01);
    repeat (3) @(posedge clock);
    chk({23'h0, irq}, 24'h000000);
    // Gated counter: closed window ignores pulses
    restart(8'hC9);
    pulses(3);
    rd24(IDX_COUNT_LOW, w);
    chk(w, 24'h000000);
    window(1'b1);
    k = 1 + ($random(seed) & 7);
    pulses(k);
    window(1'b0);
    rd24(IDX_CPW_LOW, w);
    chk(w, 24'(k));
    // Windowed counter, single acquisition
    restart(8'h8A);
    window(1'b1);
    pulses(n);
    window(1'b0);
    rd24(IDX_CPW_LOW, w);
    chk(w, 24'(n));
    pulses(k);
    window(1'b1);
    rd24(IDX_CPR_LOW, w);
    chk(w, 24'(n + k));
    rd24(IDX_IRQ_STATUS, w);
    chk({16'h0, w[7:0]}, 24'h000003);
    rd24(IDX_CONTROL_MODE, w);
    chk({16'h0, w[7:0]}, 24'h00000A);
    // Period match with and without halt
    for (int h = 1; h >= 0; h--) begin
      wr(IDX_PR_LOW, 8'h05);
      wr(IDX_PR_HIGH, 8'h00);
      wr(IDX_PR_UPPER, 8'h00);
      wr(IDX_CONTROL_PRIMARY, h[0] ? 8'hA0 : 8'h80);
      restart(8'hC8);
      pulses(7);
      rd24(IDX_COUNT_LOW, w);
      chk(w, exp_cnt(7, 24'h000005, h[0]));
      rd24(IDX_IRQ_STATUS, w);
      chk({16'h0, w[7:0]}, 24'h000004);
    end
    end_sim();
  end
endmodule : tb_top

bind signal_measure_timer measure_checker chk_i (.CLOCK(CLOCK), .ARST_N(ARST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .SIGNAL_SRC(SIGNAL_SRC), .WINDOW_SRC(WINDOW_SRC),
  .IRQ(IRQ));
